// ### scri_consts.svh
`ifndef SCRI_CONSTS_SVH
`define SCRI_CONSTS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define SCRI_IDX_OPTION 8'h39
`define SCRI_IDX_STATUS 8'h3d
`define SCRI_IDX_CONFIG 8'h3f

// ==========================================================
// system options fields
`define SCRI_OPT_RESET 8'h10
`define SCRI_OPT_APWR 7
`define SCRI_OPT_CCLK 6
`define SCRI_OPT_IRQ_EDGE 5
`define SCRI_OPT_STARTUP 4
`define SCRI_OPT_MON_EN 3
`define SCRI_OPT_MON_FORCE 2
`define SCRI_OPT_RATE_HI 1
`define SCRI_OPT_RATE_LO 0
`define SCRI_OPT_PROT_MASK 8'h37

// ==========================================================
// config control fields
`define SCRI_CFG_ROM_PLACE 7
`define SCRI_CFG_PULL_EN 4
`define SCRI_CFG_SEC_OFF 3
`define SCRI_CFG_WD_OFF 2
`define SCRI_CFG_ROM_MAP 1
`define SCRI_CFG_EE_MAP 0
`define SCRI_CFG_UNUSED 8'h60
`define SCRI_CFG_IMPL_MASK 8'h9f

// ==========================================================
// status fields
`define SCRI_STS_CAUSE_LO 0
`define SCRI_STS_CAUSE_HI 2
`define SCRI_STS_SPECIAL 3
`define SCRI_STS_EXPANDED 4
`define SCRI_STS_LOCKED 5

// ==========================================================
// timing counts (one E clock per system clock)
`define SCRI_PROT_CYC 7'd64
`define SCRI_STARTUP_CYC 12'd4000
`define SCRI_RST_HOLD_LAST 3'd3
`define SCRI_FETCH_LAST 2'd2
`define SCRI_WD_DIV_LOG2 15

// ==========================================================
// vectors and reset images
`define SCRI_VEC_HI_NORMAL 8'hff
`define SCRI_VEC_HI_SPECIAL 8'hbf
`define SCRI_VEC_LO_EXT 8'hfe
`define SCRI_VEC_LO_CM 8'hfc
`define SCRI_VEC_LO_WD 8'hfa
`define SCRI_INIT_RESET 8'h00
`define SCRI_RAM_BASE 16'h0080
`define SCRI_EE_BASE 16'h0d80
`define SCRI_ROM_BASE_HI 16'h8000
`define SCRI_ROM_BASE_LO 16'h0000
`define SCRI_TMR_COUNT_RESET 16'h0000
`define SCRI_TMR_OC_RESET 16'hffff

`endif

// ### scri_pkg.sv
package scri_pkg;
	// reset sequencer states
	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_FETCH = 3'b010,
		ST_RUN = 3'b100
	} scri_state_e;
	// recorded reset cause
	typedef enum logic [2:0] {
		CAUSE_EXT = 3'b001,
		CAUSE_CM = 3'b010,
		CAUSE_WD = 3'b100
	} scri_cause_e;
endpackage

// ### scri_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "scri_consts.svh"

module scri_watchdog #(
	parameter int DIV_LOG2 = `SCRI_WD_DIV_LOG2
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// control
	input wire logic en_i,
	input wire logic clear_i,
	input wire logic [1:0] rate_i,
	// event
	output logic timeout_o
);
	localparam int CW = DIV_LOG2 + 6;

	// ==========================================================
	// terminal count: prescale by 2^DIV_LOG2 then by 1, 4, 16 or 64
	function automatic logic [CW-1:0] wd_limit(input logic [1:0] r);
		wd_limit = {CW{1'b1}} >> (3'd6 - {r, 1'b0});
	endfunction

	logic [CW-1:0] cnt_q;
	logic timeout_q;
	wire [CW-1:0] lim = wd_limit(rate_i);
	wire at_lim = (cnt_q == lim);

	// one counter covers prescaler and scaler, so the rate acts at once
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q <= '0;
			timeout_q <= 1'b0;
		end else begin
			timeout_q <= en_i & ~clear_i & at_lim;
			if (!en_i || clear_i || at_lim) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	assign timeout_o = timeout_q;
endmodule
`default_nettype wire

// ### scri_top.sv
// Function
// - analog power bit powers the converter
// - clock select picks RC or E clock
// - irq sense: falling edge or low level
// - startup delay of 4000 cycles after stop
// - monitor enable always writable, reset clears
// - force bit enables monitor until reset
// - forced monitor resets on clock failure
// - watchdog input is E over 2^15
// - rate field scales by 1,4,16,64
// - protected bits written once in 64 cycles
// - latches govern; normal mode writes go to nonvolatile byte
// - reads return latched value, from reset or a special mode write
// - config bits six and five read one
// - special mode writes config latches directly
// - placement bit selects high or low ROM in expanded mode
// - pullup enable gates pullup assignments
// - security disable bit turns security off
// - watchdog disable bit stops watchdog resets
// - ROM and EEPROM map enable bits
// - vector address by cause and mode
// - three vector cycles, masks set
// - memory map reset images
// - timer reset images and clears
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scri_consts.svh"

module scri_top #(
	parameter int WD_DIV_LOG2 = `SCRI_WD_DIV_LOG2
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// reset sources
	input wire logic pin_reset_i,
	input wire logic clk_fail_i,
	input wire logic wd_clear_i,
	// mode straps
	input wire logic mode_b_i,
	input wire logic mode_a_i,
	// nonvolatile config byte
	input wire logic [7:0] nv_cfg_i,
	output logic nv_prog_o,
	output logic [7:0] nv_data_o,
	// external interrupt
	input wire logic irq_n_i,
	input wire logic irq_ack_i,
	output logic irq_req_o,
	// stop recovery
	input wire logic stop_exit_i,
	output logic cpu_stall_o,
	// analog and clock monitor
	output logic adc_power_o,
	output logic conv_clk_rc_o,
	output logic cm_enable_o,
	// cpu reset sequence
	output logic sys_reset_o,
	output logic vec_fetch_o,
	output logic [15:0] vec_addr_o,
	output logic cond_force_o,
	// memory map
	output logic [7:0] map_init_o,
	output logic [15:0] ram_base_o,
	output logic [15:0] eeprom_base_o,
	output logic [15:0] rom_base_o,
	output logic rom_map_o,
	output logic eeprom_map_o,
	output logic security_o,
	input wire logic [7:0] pullup_assign_i,
	output logic [7:0] pullup_o,
	// timer reset images
	output logic tmr_clear_o,
	output logic [15:0] tmr_count_o,
	output logic [15:0] tmr_oc_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	// ==========================================================
	// state
	scri_pkg::scri_state_e st_q, st_d;
	scri_pkg::scri_cause_e cause_q, cause_d;
	logic [2:0] hold_cnt_q;
	logic [1:0] fetch_cnt_q;
	logic [6:0] win_cnt_q;
	logic prot_done_q;
	logic special_q, expanded_q;
	logic [7:0] opt_q, opt_d;
	logic [7:0] cfg_q, cfg_d;
	logic dp_wr_q;
	logic [7:0] dp_idx_q;
	logic [31:0] hrdata_q;
	logic nv_prog_q;
	logic [7:0] nv_data_q;
	logic irq_n_q, irq_edge_q, irq_req_q;
	logic [11:0] stall_cnt_q;
	logic stall_q;
	logic cm_en_q, adc_q, cclk_q;
	logic [15:0] vec_addr_q;
	logic [7:0] pullup_q;
	logic rom_map_q, ee_map_q, sec_q;
	logic [15:0] rom_base_q;
	logic wd_timeout;

	// ==========================================================
	// bus decode
	wire addr_ph = hsel_i & htrans_i[1] & hready_i;
	wire [7:0] ap_idx = haddr_i[9:2];
	wire wr_opt = dp_wr_q & (dp_idx_q == `SCRI_IDX_OPTION) & (st_q == scri_pkg::ST_RUN);
	wire wr_cfg = dp_wr_q & (dp_idx_q == `SCRI_IDX_CONFIG) & (st_q == scri_pkg::ST_RUN);
	wire [7:0] wbyte = hwdata_i[7:0];

	// ==========================================================
	// reset sequencer
	wire in_run = (st_q == scri_pkg::ST_RUN);
	wire hold_done = (hold_cnt_q == `SCRI_RST_HOLD_LAST) & ~pin_reset_i;
	wire cm_trip = clk_fail_i & cm_en_q;
	wire [7:0] vec_hi = mode_b_i ? `SCRI_VEC_HI_NORMAL : `SCRI_VEC_HI_SPECIAL;
	wire [7:0] vec_lo = (cause_q == scri_pkg::CAUSE_CM) ? `SCRI_VEC_LO_CM :
		(cause_q == scri_pkg::CAUSE_WD) ? `SCRI_VEC_LO_WD : `SCRI_VEC_LO_EXT;

	// next state and cause, pin reset outranks clock monitor outranks watchdog
	always_comb begin
		st_d = st_q;
		cause_d = cause_q;
		unique case (st_q)
			scri_pkg::ST_HOLD: begin
				if (hold_done) begin
					st_d = scri_pkg::ST_FETCH;
				end
			end
			scri_pkg::ST_FETCH: begin
				if (fetch_cnt_q == `SCRI_FETCH_LAST) begin
					st_d = scri_pkg::ST_RUN;
				end
			end
			scri_pkg::ST_RUN: begin
				if (pin_reset_i) begin
					st_d = scri_pkg::ST_HOLD;
					cause_d = scri_pkg::CAUSE_EXT;
				end else if (cm_trip) begin
					st_d = scri_pkg::ST_HOLD;
					cause_d = scri_pkg::CAUSE_CM;
				end else if (wd_timeout) begin
					st_d = scri_pkg::ST_HOLD;
					cause_d = scri_pkg::CAUSE_WD;
				end
			end
			default: begin
				st_d = scri_pkg::ST_HOLD;
				cause_d = scri_pkg::CAUSE_EXT;
			end
		endcase
	end

	// sequencer registers; straps caught at release, never under reset
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= scri_pkg::ST_HOLD;
			cause_q <= scri_pkg::CAUSE_EXT;
			hold_cnt_q <= 3'h0;
			fetch_cnt_q <= 2'h0;
			special_q <= 1'b0;
			expanded_q <= 1'b0;
			vec_addr_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			cause_q <= cause_d;
			hold_cnt_q <= (st_q == scri_pkg::ST_HOLD && !pin_reset_i && !hold_done) ?
				hold_cnt_q + 3'h1 : 3'h0;
			fetch_cnt_q <= (st_q == scri_pkg::ST_FETCH) ? fetch_cnt_q + 2'h1 : 2'h0;
			if (st_q == scri_pkg::ST_HOLD && hold_done) begin
				special_q <= ~mode_b_i;
				expanded_q <= mode_a_i;
				vec_addr_q <= {vec_hi, vec_lo};
			end
		end
	end

	// ==========================================================
	// system options with time-protected fields
	wire win_open = (win_cnt_q < `SCRI_PROT_CYC);
	wire prot_open = special_q | (~prot_done_q & win_open);
	wire [7:0] prot_m = `SCRI_OPT_PROT_MASK;
	wire [7:0] opt_wr = (wbyte & ~prot_m) | ((prot_open ? wbyte : opt_q) & prot_m);
	wire [7:0] force_keep = {5'h00, opt_q[`SCRI_OPT_MON_FORCE], 2'h0};

	// force bit can only be set, so a stray write never drops the monitor
	always_comb begin
		opt_d = opt_q;
		if (st_q != scri_pkg::ST_RUN) begin
			opt_d = `SCRI_OPT_RESET;
		end else if (wr_opt) begin
			opt_d = opt_wr | force_keep;
		end
	end

	// ==========================================================
	// config latches: loaded from the cells only during reset
	always_comb begin
		cfg_d = cfg_q;
		if (st_q == scri_pkg::ST_HOLD) begin
			cfg_d = nv_cfg_i & `SCRI_CFG_IMPL_MASK;
		end else if (wr_cfg && special_q) begin
			cfg_d = wbyte & `SCRI_CFG_IMPL_MASK;
		end
	end

	// read mux uses next option and config values so a read right after a write is coherent
	wire [7:0] sts_byte = {2'h0, ~(prot_open), expanded_q, special_q, cause_q};
	wire [7:0] rd_byte = (ap_idx == `SCRI_IDX_OPTION) ? opt_d :
		(ap_idx == `SCRI_IDX_CONFIG) ? (cfg_d | `SCRI_CFG_UNUSED) :
		(ap_idx == `SCRI_IDX_STATUS) ? sts_byte : 8'h00;

	// bus and register state
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			opt_q <= `SCRI_OPT_RESET;
			cfg_q <= 8'h00;
			dp_wr_q <= 1'b0;
			dp_idx_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			win_cnt_q <= 7'h00;
			prot_done_q <= 1'b0;
			nv_prog_q <= 1'b0;
			nv_data_q <= 8'h00;
		end else begin
			opt_q <= opt_d;
			cfg_q <= cfg_d;
			dp_wr_q <= addr_ph & hwrite_i;
			dp_idx_q <= addr_ph ? ap_idx : 8'h00;
			if (addr_ph && !hwrite_i) begin
				hrdata_q <= {24'h000000, rd_byte};
			end
			if (!in_run) begin
				win_cnt_q <= 7'h00;
				prot_done_q <= 1'b0;
			end else begin
				if (win_open) begin
					win_cnt_q <= win_cnt_q + 7'h01;
				end
				if (wr_opt && !special_q) begin
					prot_done_q <= 1'b1;
				end
			end
			// normal mode writes reach only the nonvolatile byte
			nv_prog_q <= wr_cfg & ~special_q;
			if (wr_cfg && !special_q) begin
				nv_data_q <= wbyte & `SCRI_CFG_IMPL_MASK;
			end
		end
	end

	// ==========================================================
	// watchdog
	scri_watchdog #(
		.DIV_LOG2(WD_DIV_LOG2)
	) u_wd (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.en_i(in_run & ~cfg_q[`SCRI_CFG_WD_OFF]),
		.clear_i(wd_clear_i),
		.rate_i(opt_q[`SCRI_OPT_RATE_HI:`SCRI_OPT_RATE_LO]),
		.timeout_o(wd_timeout)
	);

	// ==========================================================
	// irq sense and stop recovery
	wire irq_fall = irq_n_q & ~irq_n_i;
	wire irq_edge_d = (irq_fall & opt_q[`SCRI_OPT_IRQ_EDGE]) | (irq_edge_q & ~irq_ack_i);
	wire [11:0] stall_cnt_d = (stop_exit_i && opt_q[`SCRI_OPT_STARTUP]) ? `SCRI_STARTUP_CYC :
		(stall_cnt_q != 12'h000) ? stall_cnt_q - 12'h001 : 12'h000;

	// set wins over the acknowledge; delay bit clear bypasses the stall
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_n_q <= 1'b1;
			irq_edge_q <= 1'b0;
			irq_req_q <= 1'b0;
			stall_cnt_q <= 12'h000;
			stall_q <= 1'b0;
		end else begin
			irq_n_q <= irq_n_i;
			irq_edge_q <= irq_edge_d;
			irq_req_q <= opt_q[`SCRI_OPT_IRQ_EDGE] ? irq_edge_d : ~irq_n_i;
			stall_cnt_q <= stall_cnt_d;
			stall_q <= (stall_cnt_d != 12'h000);
		end
	end

	// ==========================================================
	// control outputs registered from the next option value and the config latches
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cm_en_q <= 1'b0;
			adc_q <= 1'b0;
			cclk_q <= 1'b0;
			pullup_q <= 8'h00;
			rom_map_q <= 1'b0;
			ee_map_q <= 1'b0;
			sec_q <= 1'b1;
			rom_base_q <= `SCRI_ROM_BASE_HI;
		end else begin
			cm_en_q <= opt_d[`SCRI_OPT_MON_EN] | opt_d[`SCRI_OPT_MON_FORCE];
			adc_q <= opt_d[`SCRI_OPT_APWR];
			cclk_q <= opt_d[`SCRI_OPT_CCLK];
			pullup_q <= cfg_q[`SCRI_CFG_PULL_EN] ? pullup_assign_i : 8'h00;
			rom_map_q <= cfg_q[`SCRI_CFG_ROM_MAP];
			ee_map_q <= cfg_q[`SCRI_CFG_EE_MAP];
			sec_q <= ~cfg_q[`SCRI_CFG_SEC_OFF];
			// low placement is honoured only in expanded mode
			rom_base_q <= (cfg_q[`SCRI_CFG_ROM_PLACE] | ~expanded_q) ?
				`SCRI_ROM_BASE_HI : `SCRI_ROM_BASE_LO;
		end
	end

	// ==========================================================
	// output wiring, each from a flop or a constant
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_q;
	assign nv_prog_o = nv_prog_q;
	assign nv_data_o = nv_data_q;
	assign irq_req_o = irq_req_q;
	assign cpu_stall_o = stall_q;
	assign adc_power_o = adc_q;
	assign conv_clk_rc_o = cclk_q;
	assign cm_enable_o = cm_en_q;
	assign sys_reset_o = st_q[0];
	assign vec_fetch_o = st_q[1];
	assign vec_addr_o = vec_addr_q;
	assign cond_force_o = ~st_q[2];
	assign map_init_o = `SCRI_INIT_RESET;
	assign ram_base_o = `SCRI_RAM_BASE;
	assign eeprom_base_o = `SCRI_EE_BASE;
	assign rom_base_o = rom_base_q;
	assign rom_map_o = rom_map_q;
	assign eeprom_map_o = ee_map_q;
	assign security_o = sec_q;
	assign pullup_o = pullup_q;
	assign tmr_clear_o = st_q[0];
	assign tmr_count_o = `SCRI_TMR_COUNT_RESET;
	assign tmr_oc_o = `SCRI_TMR_OC_RESET;

	// ==========================================================
	// assertions
	a_cfg_unused_ones: assert property (
		(addr_ph && !hwrite_i && ap_idx == `SCRI_IDX_CONFIG) |=> (hrdata_o[6:5] == 2'b11)
	) else $error("config bits six and five not read as one");

	a_force_sticky: assert property (
		(in_run && opt_q[`SCRI_OPT_MON_FORCE])
		|=> (opt_q[`SCRI_OPT_MON_FORCE] || st_q == scri_pkg::ST_HOLD)
	) else $error("forced monitor dropped before reset");

	a_cm_fail_reset: assert property (
		(in_run && clk_fail_i && cm_enable_o && !pin_reset_i)
		|=> (st_q == scri_pkg::ST_HOLD && cause_q == scri_pkg::CAUSE_CM)
	) else $error("clock failure did not start monitor reset");

	a_prot_locked: assert property (
		(in_run && !special_q && !prot_open)
		|=> (((opt_q ^ $past(opt_q)) & `SCRI_OPT_PROT_MASK) == 8'h00 || !in_run)
	) else $error("protected option bits changed after lock");

	a_fetch_three: assert property (
		$rose(vec_fetch_o) |-> vec_fetch_o[*3] ##1 (!vec_fetch_o && !cond_force_o)
	) else $error("vector fetch not three cycles");

	a_vector_wd: assert property (
		(vec_fetch_o && cause_q == scri_pkg::CAUSE_WD && !special_q)
		|-> (vec_addr_o == {`SCRI_VEC_HI_NORMAL, `SCRI_VEC_LO_WD})
	) else $error("watchdog vector address wrong");

	a_pullup_gate: assert property (
		!cfg_q[`SCRI_CFG_PULL_EN] |=> (pullup_o == 8'h00)
	) else $error("pullups active while disabled");

	a_cfg_nv_write: assert property (
		(wr_cfg && !special_q) |=> (nv_prog_o && $stable(cfg_q))
	) else $error("normal config write touched latches");

	a_delay_stall: assert property (
		(stop_exit_i && opt_q[`SCRI_OPT_STARTUP]) |=> cpu_stall_o[*8]
	) else $error("startup delay not imposed");

	a_irq_level: assert property (
		!opt_q[`SCRI_OPT_IRQ_EDGE] |=> (irq_req_o == !$past(irq_n_i))
	) else $error("level irq request wrong");

	a_wd_disabled: assert property (
		(in_run && $past(cfg_q[`SCRI_CFG_WD_OFF]) && cfg_q[`SCRI_CFG_WD_OFF]) |-> !wd_timeout
	) else $error("watchdog fired while disabled");
endmodule
`default_nettype wire

// ### scri_nv_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// nonvolatile config cells beside the device
module scri_nv_model (
	// clock
	input wire logic sys_clk_i,
	// factory preset of the cells
	input wire logic load_i,
	input wire logic [7:0] load_val_i,
	// programming strobe from the device
	input wire logic prog_i,
	input wire logic [7:0] prog_val_i,
	// cell contents seen by the device
	output logic [7:0] cells_o
);
	// cells change only when preset or programmed, the latches see it after a reset
	always_ff @(posedge sys_clk_i) begin
		if (load_i) begin
			cells_o <= load_val_i;
		end else if (prog_i) begin
			cells_o <= prog_val_i;
		end
	end
endmodule

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scri_consts.svh"

module tb_top;
	// ==========================================================
	// signals
	logic sys_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic pin_reset_i = 1'b0, clk_fail_i = 1'b0, wd_clear_i = 1'b0;
	logic mode_b_i = 1'b1, mode_a_i = 1'b0;
	logic irq_n_i = 1'b1, irq_ack_i = 1'b0, stop_exit_i = 1'b0;
	logic nv_load = 1'b1;
	logic [7:0] nv_val = 8'h04, pullup_assign_i = 8'h5a, nv_cells;
	logic hreadyout_o, hresp_o, nv_prog_o, irq_req_o, cpu_stall_o;
	logic adc_power_o, conv_clk_rc_o, cm_enable_o, sys_reset_o, vec_fetch_o, cond_force_o;
	logic rom_map_o, eeprom_map_o, security_o, tmr_clear_o;
	logic [31:0] hrdata_o, rdat;
	logic [7:0] nv_data_o, map_init_o, pullup_o, r, w;
	logic [15:0] vec_addr_o, ram_base_o, eeprom_base_o, rom_base_o, tmr_count_o, tmr_oc_o;
	int err_count = 0, cmp_count = 0, seed = 23, n;

	// free running system clock
	always #5 sys_clk_i = ~sys_clk_i;

	// ==========================================================
	// design and its nonvolatile cells
	scri_top #(.WD_DIV_LOG2(3)) scri_top_i (.sys_clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o,
		.hrdata_o, .pin_reset_i, .clk_fail_i, .wd_clear_i, .mode_b_i, .mode_a_i,
		.nv_cfg_i(nv_cells), .nv_prog_o, .nv_data_o, .irq_n_i, .irq_ack_i, .irq_req_o,
		.stop_exit_i, .cpu_stall_o, .adc_power_o, .conv_clk_rc_o, .cm_enable_o, .sys_reset_o,
		.vec_fetch_o, .vec_addr_o, .cond_force_o, .map_init_o, .ram_base_o, .eeprom_base_o,
		.rom_base_o, .rom_map_o, .eeprom_map_o, .security_o, .pullup_assign_i, .pullup_o,
		.tmr_clear_o, .tmr_count_o, .tmr_oc_o);
	scri_nv_model scri_nv_model_i (.sys_clk_i, .load_i(nv_load), .load_val_i(nv_val),
		.prog_i(nv_prog_o), .prog_val_i(nv_data_o), .cells_o(nv_cells));

	// ==========================================================
	// report and compare
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task chk(input logic [47:0] got, input logic [47:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task fail(input string what);
		err_count++;
		$display("Error %0t: %s timed out", $time, what);
		complete_run();
	endtask

	// ==========================================================
	// bounded waits and bus cycles
	function automatic logic pick(input int k);
		return k == 0 ? vec_fetch_o : k == 1 ? sys_reset_o : nv_prog_o;
	endfunction

	task automatic wait_sig(input int s, input logic v, input string what);
		int k;
		for (k = 0; pick(s) !== v && k < 5000; k++) @(posedge sys_clk_i);
		if (pick(s) !== v) begin
			fail(what);
		end
	endtask

	// one single transfer; upper data bits are noise the slave must ignore
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int k;
		hsel_i <= 1'b1;
		haddr_i <= {22'h0, idx, 2'b00};
		htrans_i <= 2'b10;
		hwrite_i <= wr;
		@(posedge sys_clk_i);
		for (k = 0; hreadyout_o !== 1'b1 && k < 20; k++) @(posedge sys_clk_i);
		if (k >= 20) begin
			fail("bus address");
		end
		htrans_i <= 2'b00;
		hsel_i <= 1'b0;
		hwdata_i <= ($random(seed) & 32'hffffff00) | {24'h0, wd};
		@(posedge sys_clk_i);
		for (k = 0; hreadyout_o !== 1'b1 && k < 20; k++) @(posedge sys_clk_i);
		rdat = hrdata_o;
		if (k >= 20) begin
			fail("bus");
		end
	endtask

	task rdchk(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
		bus(1'b0, idx, 8'h00);
		chk(rdat & {24'hffffff, m}, {24'h0, e & m}, "read");
	endtask

	// ==========================================================
	// reset sequence helpers
	task pin_rst;
		pin_reset_i <= 1'b1;
		wait_sig(1, 1'b1, "reset");
		pin_reset_i <= 1'b0;
	endtask

	task boot(input logic [15:0] ev);
		wait_sig(0, 1'b1, "fetch");
		chk(vec_addr_o, ev, "vector");
		chk(cond_force_o, 1'b1, "masks");
		for (n = 0; vec_fetch_o === 1'b1 && n < 9; n++) @(posedge sys_clk_i);
		chk(n, 3, "fetch cycles");
		chk(cond_force_o, 1'b0, "masks off");
	endtask

	task stop_pulse;
		stop_exit_i <= 1'b1;
		@(posedge sys_clk_i);
		stop_exit_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask

	function automatic logic [7:0] sts(input logic [2:0] cause, input logic sp);
		return {3'b000, mode_a_i, sp, cause};
	endfunction

	// map outputs follow the latches; low rom only counts in expanded mode
	function automatic logic [47:0] map_exp(input logic [7:0] c);
		return {c[1], c[0], ~c[3], (c[7] | ~mode_a_i) ? 16'h8000 : 16'h0000,
			c[4] ? pullup_assign_i : 8'h00};
	endfunction

	task chk_map(input logic [7:0] c);
		chk({rom_map_o, eeprom_map_o, security_o, rom_base_o, pullup_o}, map_exp(c), "map");
	endtask

	// ==========================================================
	// hang guard
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		fail("run");
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge sys_clk_i);
		chk({map_init_o, ram_base_o, eeprom_base_o}, {8'h00, 16'h0080, 16'h0d80}, "map");
		chk({tmr_clear_o, tmr_count_o, tmr_oc_o}, {1'b1, 16'h0000, 16'hffff}, "timer");
		chk({hresp_o, cond_force_o, vec_fetch_o, sys_reset_o}, 4'h5, "reset state");
		arst_n_i <= 1'b1;
		nv_load <= 1'b0;
		boot(16'hfffe);
		// random cell contents, expanded strap toggled, watchdog kept off
		for (int k = 0; k < 3; k++) begin
			r = ($random(seed) & 8'h9f) | 8'h04;
			nv_load <= 1'b1;
			nv_val <= r;
			mode_a_i <= k[0];
			pullup_assign_i <= $random(seed);
			@(posedge sys_clk_i);
			nv_load <= 1'b0;
			pin_rst();
			boot(16'hfffe);
			rdchk(`SCRI_IDX_CONFIG, r | 8'h60, 8'hff);
			repeat (40) @(posedge sys_clk_i);
			chk_map(r);
			chk(sys_reset_o, 1'b0, "no watchdog");
			rdchk(`SCRI_IDX_STATUS, sts(3'b001, 1'b0), 8'h1f);
		end
		pin_rst();
		boot(16'hfffe);
		rdchk(`SCRI_IDX_OPTION, 8'h10, 8'hff);
		rdchk(`SCRI_IDX_STATUS, sts(3'b001, 1'b0), 8'h3f);
		irq_n_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		chk(irq_req_o, 1'b1, "irq level");
		irq_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		chk(irq_req_o, 1'b0, "irq level off");
		// first write in the window: edge irq, delay on, monitor off before stop
		r = $random(seed);
		w = {r[7:6], 4'hc, r[1:0]};
		bus(1'b1, `SCRI_IDX_OPTION, w);
		rdchk(`SCRI_IDX_OPTION, w, 8'hff);
		chk({adc_power_o, conv_clk_rc_o, cm_enable_o}, {w[7:6], 1'b0}, "options");
		irq_n_i <= 1'b0;
		@(posedge sys_clk_i);
		irq_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		chk(irq_req_o, 1'b1, "irq edge held");
		irq_ack_i <= 1'b1;
		@(posedge sys_clk_i);
		irq_ack_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		chk(irq_req_o, 1'b0, "irq acked");
		stop_pulse();
		for (n = 0; cpu_stall_o === 1'b1 && n < 4100; n++) @(posedge sys_clk_i);
		chk(n, 4000, "stop delay");
		bus(1'b1, `SCRI_IDX_OPTION, ~w);
		rdchk(`SCRI_IDX_OPTION, (~w & 8'hc8) | (w & 8'h37), 8'hff);
		chk({adc_power_o, conv_clk_rc_o, cm_enable_o}, {~w[7:6], 1'b1}, "opt");
		// clock failure with the monitor on
		clk_fail_i <= 1'b1;
		wait_sig(1, 1'b1, "monitor reset");
		clk_fail_i <= 1'b0;
		boot(16'hfffc);
		rdchk(`SCRI_IDX_STATUS, sts(3'b010, 1'b0), 8'h3f);
		rdchk(`SCRI_IDX_OPTION, 8'h10, 8'hff);
		// normal config write reaches the cells only, watchdog enabled next
		r = $random(seed) & 8'h9b;
		bus(1'b1, `SCRI_IDX_CONFIG, r);
		wait_sig(2, 1'b1, "program");
		chk(nv_data_o, r, "nv data");
		rdchk(`SCRI_IDX_CONFIG, nv_val | 8'h60, 8'hff);
		wd_clear_i <= 1'b1;
		pin_rst();
		boot(16'hfffe);
		rdchk(`SCRI_IDX_CONFIG, r | 8'h60, 8'hff);
		bus(1'b1, `SCRI_IDX_OPTION, 8'h11);
		wd_clear_i <= 1'b0;
		for (n = 0; sys_reset_o !== 1'b1 && n < 99; n++) @(posedge sys_clk_i);
		chk(n >= 30 && n <= 34, 1'b1, "watchdog period");
		wd_clear_i <= 1'b1;
		boot(16'hfffa);
		rdchk(`SCRI_IDX_STATUS, sts(3'b100, 1'b0), 8'h3f);
		bus(1'b1, `SCRI_IDX_CONFIG, r | 8'h04);
		wait_sig(2, 1'b1, "program");
		// special mode: latches written directly, options never locked
		mode_b_i <= 1'b0;
		pin_rst();
		wd_clear_i <= 1'b0;
		boot(16'hbffe);
		rdchk(`SCRI_IDX_STATUS, sts(3'b001, 1'b1), 8'h1f);
		r = ($random(seed) & 8'h9f) | 8'h04;
		bus(1'b1, `SCRI_IDX_CONFIG, r);
		rdchk(`SCRI_IDX_CONFIG, r | 8'h60, 8'hff);
		chk_map(r);
		repeat (70) @(posedge sys_clk_i);
		bus(1'b1, `SCRI_IDX_OPTION, 8'h37);
		rdchk(`SCRI_IDX_OPTION, 8'h37, 8'hff);
		bus(1'b1, `SCRI_IDX_OPTION, 8'h00);
		rdchk(`SCRI_IDX_OPTION, 8'h04, 8'hff);
		chk(cm_enable_o, 1'b1, "forced monitor");
		stop_pulse();
		chk(cpu_stall_o, 1'b0, "no delay");
		clk_fail_i <= 1'b1;
		wait_sig(1, 1'b1, "forced reset");
		clk_fail_i <= 1'b0;
		boot(16'hbffc);
		complete_run();
	end
endmodule

`default_nettype wire
